/* File: rtl/console_step_control.sv */
// console run/step/hold control, sense gating, break and memory thermal power
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module console_step_control
  import console_step_pkg::*;
#(
  parameter int unsigned W = WORD_W      // instruction word width
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  // console switches, asynchronous
  input  wire logic              run_sw,
  input  wire logic              step_sw,
  input  wire logic              break_sw,
  input  wire logic              restore_sw,
  input  wire logic              supply_sw,
  input  wire logic              hold_sw,
  input  wire logic              maint_hold,
  input  wire logic [SENSE_N-1:0] sense_sw,
  input  wire logic              overtemp,
  input  wire logic              reg_entry_req,
  input  wire logic              reg_clear_req,
  // processor sequencer side
  input  wire logic              cond_inst,
  input  wire logic [W-1:0]      cur_inst,
  input  var  seq_ans_type       seq_ans,
  output seq_req_type            seq_req,
  output logic [W-1:0]           pc_r,
  output logic [W-1:0]           ir_r,
  output logic                   entry_allow,
  output logic                   clear_allow,
  output logic                   mem_power_on,
  output logic                   pfail_irq,
  output lamp_type               lamps,
  // software port
  input  wire logic [3:0]        reg_addr,
  input  wire logic [W-1:0]      reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [W-1:0]           reg_rdata,
  output logic                   irq
);

  initial begin
    if (W < SENSE_LSB + SENSE_N) $error("word too narrow for sense bits");
  end

  // synchronised switch vector
  logic [SW_N-1:0] sw_lvl;               // synchronised levels
  logic [SW_N-1:0] sw_rise;              // press pulses
  logic [SW_N-1:0] sw_fall;              // release pulses
  logic [SENSE_N-1:0] sense_m;           // sense first stage
  logic [SENSE_N-1:0] sense_s;           // sense synchronised
  logic            mhold_m;              // maintenance first stage
  logic            mhold_s;              // maintenance synchronised

  switch_sync #(.N(SW_N)) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .sw_raw   ({overtemp, hold_sw, supply_sw, restore_sw, break_sw, step_sw, run_sw}),
    .sw_level (sw_lvl),
    .sw_rise  (sw_rise),
    .sw_fall  (sw_fall)
  );

  // sense and maintenance levels need only synchronising
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sense_m <= '0;
      sense_s <= '0;
      mhold_m <= 1'b0;
      mhold_s <= 1'b0;
    end else begin
      sense_m <= sense_sw;
      sense_s <= sense_m;
      mhold_m <= maint_hold;
      mhold_s <= mhold_m;
    end
  end

  seq_state_type state_r;                // sequencer state
  seq_state_type state_nxt;
  logic          hold_r;                 // hold mode latch
  logic          step_pend_r;            // step requested while running
  logic          brk_pend_r;             // break waiting for run slot
  logic          mem_off_r;              // memory power cut by thermal trip
  logic          supply_off_seen_r;      // supply cycled off while tripped
  logic [EV_N-1:0] stat_r;               // sticky events
  logic [EV_N-1:0] mask_r;               // interrupt mask
  logic          halt_ev;                // halt instruction completed
  logic          trip_ev;                // thermal trip this cycle
  logic          hold_eff;               // effective hold mode
  logic          running;                // continuous operation

  assign running = (state_r == ST_RUN) || (state_r == ST_FORCE);

  // hold latch follows console only when halted in step
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hold_r <= 1'b0;
    end else if (state_r == ST_HALT) begin
      hold_r <= sw_lvl[SW_HOLD];         // RULE2
    end
  end

  // maintenance input forces hold during continuous run
  assign hold_eff = (state_r == ST_HALT || state_r == ST_EXEC || state_r == ST_FETCH)
                    ? hold_r : mhold_s; // RULE2

  // condition: switches ANDed with bits 6-8, same in run and step
  assign seq_req.cond_ok = cond_inst
      & (|(sense_s & cur_inst[SENSE_LSB +: SENSE_N])); // RULE3 RULE4

  // step press remembered while running
  always_ff @(posedge core_clk) begin
    if (rst) begin
      step_pend_r <= 1'b0;
    end else if (state_r == ST_RUN && step_pend_r) begin
      step_pend_r <= 1'b0;
    end else if (running && sw_rise[SW_STEP]) begin
      step_pend_r <= 1'b1;               // RULE16
    end
  end

  // break press only counts in continuous run
  always_ff @(posedge core_clk) begin
    if (rst) begin
      brk_pend_r <= 1'b0;
    end else if (state_r == ST_FORCE) begin
      brk_pend_r <= 1'b0;
    end else if (state_r == ST_RUN && sw_rise[SW_BREAK]) begin
      brk_pend_r <= 1'b1;                // RULE5
    end
  end

  assign halt_ev = seq_ans.done && seq_ans.is_halt && state_r != ST_HALT;

  // sequencer next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_HALT: begin
        if (sw_rise[SW_RUN] && !mem_off_r) begin
          state_nxt = ST_RUN;
        end else if (sw_rise[SW_STEP] && !mem_off_r) begin
          state_nxt = ST_EXEC;           // RULE10
        end
      end
      ST_EXEC: begin
        // wait for whole instruction, indirection included
        if (seq_ans.done) begin
          state_nxt = hold_eff ? ST_HALT : ST_FETCH; // RULE12 RULE1
        end
      end
      ST_FETCH: begin
        if (seq_ans.done) begin
          state_nxt = ST_HALT;           // RULE10
        end
      end
      ST_RUN: begin
        if (step_pend_r || halt_ev || mem_off_r) begin
          state_nxt = ST_HALT;           // RULE16 RULE17
        end else if (brk_pend_r && seq_ans.done) begin
          state_nxt = ST_FORCE;          // RULE5
        end
      end
      ST_FORCE: begin
        if (seq_ans.done) begin
          state_nxt = (seq_ans.is_jump || seq_ans.is_halt) ? ST_HALT : ST_RUN; // RULE6
        end
      end
      default: state_nxt = ST_HALT;
    endcase
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r <= ST_HALT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // requests to the processor sequencer
  assign seq_req.exec      = (state_r == ST_EXEC) || (state_r == ST_RUN);
  assign seq_req.fetch     = (state_r == ST_FETCH);
  assign seq_req.force_fix = (state_r == ST_FORCE);

  // program counter: advances after each executed instruction except a forced non-jump
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pc_r <= PC_RESET;
    end else if ((state_r == ST_EXEC || running) && seq_ans.done
                 && !(state_r == ST_FORCE && !seq_ans.is_jump)) begin
      pc_r <= seq_ans.pc_adv ? seq_ans.pc_load : pc_r; // RULE11 RULE13
    end
  end

  // instruction register: load on fetch unless held
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ir_r <= IR_RESET;
    end else if (state_r == ST_FETCH && seq_ans.done) begin
      ir_r <= seq_ans.fetched;           // RULE10
    end else if (state_r == ST_RUN && seq_ans.done && !hold_eff) begin
      ir_r <= seq_ans.fetched;           // RULE1
    end
  end

  // console register entry gated off while running
  assign entry_allow = reg_entry_req & ~running; // RULE15
  assign clear_allow = reg_clear_req & ~running; // RULE15

  // thermal trip and power restore
  assign trip_ev = sw_rise[SW_OVERT] && !mem_off_r;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mem_off_r         <= 1'b0;
      supply_off_seen_r <= 1'b0;
    end else if (trip_ev) begin
      mem_off_r         <= 1'b1;         // RULE7
      supply_off_seen_r <= 1'b0;
    end else if (mem_off_r) begin
      if (sw_rise[SW_RESTORE] || (supply_off_seen_r && sw_rise[SW_SUPPLY])) begin
        mem_off_r <= 1'b0;               // RULE9
      end
      if (sw_fall[SW_SUPPLY]) begin
        supply_off_seen_r <= 1'b1;       // RULE9
      end
    end
  end

  assign mem_power_on = sw_lvl[SW_SUPPLY] & ~mem_off_r; // RULE7
  assign pfail_irq    = trip_ev;                       // RULE7

  // run and step lamps registered from next state, the others from hold and power state
  always_ff @(posedge core_clk) begin
    if (rst) begin
      lamps <= '0;
    end else begin
      lamps.run     <= (state_nxt == ST_RUN) || (state_nxt == ST_FORCE); // RULE17
      lamps.step    <= !((state_nxt == ST_RUN) || (state_nxt == ST_FORCE)); // RULE16
      lamps.hold    <= hold_r;
      lamps.supply  <= sw_lvl[SW_SUPPLY] & ~(mem_off_r | trip_ev); // RULE8
      lamps.restore <= mem_off_r | trip_ev; // RULE8
    end
  end

  // sticky status: set wins over write-one clear
  logic [EV_N-1:0] ev_vec;
  assign ev_vec = {halt_ev, trip_ev, (state_r == ST_RUN && sw_rise[SW_BREAK])};

  always_ff @(posedge core_clk) begin
    if (rst) begin
      stat_r <= '0;
    end else begin
      stat_r <= (stat_r & ~((reg_wr && reg_addr == REG_STATUS)
                            ? reg_wdata[EV_N-1:0] : '0)) | ev_vec;
    end
  end

  // mask register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mask_r <= MASK_RESET;
    end else if (reg_wr && reg_addr == REG_MASK) begin
      mask_r <= reg_wdata[EV_N-1:0];
    end
  end

  assign irq = |(stat_r & mask_r);

  // read data one cycle after strobe, zero otherwise
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_STATUS: reg_rdata <= W'(stat_r);
        REG_MASK:   reg_rdata <= W'(mask_r);
        REG_STATE:  reg_rdata <= W'({mem_off_r, hold_eff, running, state_r});
        REG_PC:     reg_rdata <= pc_r;
        REG_IR:     reg_rdata <= ir_r;
        default:    reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // a step press while running ends the run within three cycles
  property p_step_halts;
    @(posedge core_clk) disable iff (rst)
      (state_r == ST_RUN && sw_rise[SW_STEP]) |-> ##[1:3] (state_r == ST_HALT);
  endproperty
  a_step_halts: assert property (p_step_halts) else $error("step did not halt run"); // RULE16

  // run lamp dark in the same cycle the halt state is reached
  property p_run_lamp;
    @(posedge core_clk) disable iff (rst)
      $rose(state_r == ST_HALT) |-> !lamps.run && lamps.step;
  endproperty
  a_run_lamp: assert property (p_run_lamp) else $error("run lamp lit while halted"); // RULE17

  // held instruction register unchanged across a step
  property p_hold_keeps_ir;
    @(posedge core_clk) disable iff (rst)
      (state_r == ST_EXEC && hold_eff && seq_ans.done) |=> $stable(ir_r) && state_r == ST_HALT;
  endproperty
  a_hold_keeps_ir: assert property (p_hold_keeps_ir) else $error("held ir reloaded"); // RULE1

  // trip cuts memory power next cycle and lights restore lamp
  property p_trip;
    @(posedge core_clk) disable iff (rst)
      trip_ev |=> !mem_power_on && lamps.restore && !lamps.supply;
  endproperty
  a_trip: assert property (p_trip) else $error("thermal trip not handled"); // RULE7 RULE8

  // restore press brings memory power back
  property p_restore;
    @(posedge core_clk) disable iff (rst)
      (mem_off_r && sw_rise[SW_RESTORE] && !trip_ev) |=> !mem_off_r;
  endproperty
  a_restore: assert property (p_restore) else $error("restore press ignored"); // RULE9

  // forced jump or halt instruction halts, else run
  property p_force_end;
    @(posedge core_clk) disable iff (rst)
      (state_r == ST_FORCE && seq_ans.done) |=>
        (state_r == ((($past(seq_ans.is_jump) || $past(seq_ans.is_halt))) ? ST_HALT : ST_RUN));
  endproperty
  a_force_end: assert property (p_force_end) else $error("wrong state after forced op"); // RULE6

  // entry never allowed while running
  property p_entry_block;
    @(posedge core_clk) disable iff (rst)
      running |-> !entry_allow && !clear_allow;
  endproperty
  a_entry_block: assert property (p_entry_block) else $error("entry accepted in run"); // RULE15

  // condition requires matching switch and bit
  property p_sense;
    @(posedge core_clk) disable iff (rst)
      seq_req.cond_ok |-> cond_inst && (sense_s & cur_inst[SENSE_LSB +: SENSE_N]) != '0;
  endproperty
  a_sense: assert property (p_sense) else $error("condition without switch"); // RULE4

endmodule : console_step_control
`default_nettype wire

/* File: rtl/console_step_pkg.sv */
// constants and carrier types for the console step control block
// Summary of operation
// RULE1 - hold mode: step executes, advances counter, keeps instruction
// RULE2 - hold switch only when halted; maintenance forces
// RULE3 - switch-conditional jump/mark/execute need matching switch on
// RULE4 - condition switches ANDed with instruction bits 6-8
// RULE5 - break press in run forces fixed-location instruction
// RULE6 - resume after forced instruction unless jump or halt
// RULE7 - over-temperature cuts memory power, raises power-fail interrupt
// RULE8 - over-temperature lights restore lamp, darkens supply lamp
// RULE9 - restore by restore press or supply off-on
// RULE10 - step executes held instruction then fetches next
// RULE11 - counter holds address of next fetch
// RULE12 - step completes whole instruction including indirection
// RULE13 - held relative store writes successive locations
// RULE14 - block-transfer peripherals unreliable when stepped
// RULE15 - register entry and clear ignored while running
// RULE16 - step press in run halts, swaps lamps
// RULE17 - step press or halt instruction stops run
// RULE18 - switches synchronised, one event per press
package console_step_pkg;

  localparam int unsigned WORD_W          = 16;      // instruction word width
  localparam int unsigned SENSE_LSB       = 6;       // lowest sense-select bit
  localparam int unsigned SENSE_N         = 3;       // number of condition switches
  localparam int unsigned SW_N            = 7;       // synchronised switch count
  localparam logic [WORD_W-1:0] PC_RESET  = 16'h0000;// counter after reset
  localparam logic [WORD_W-1:0] IR_RESET  = 16'h0000;// instruction after reset

  // switch index into the synchronised vector
  localparam int unsigned SW_RUN     = 0;
  localparam int unsigned SW_STEP    = 1;
  localparam int unsigned SW_BREAK   = 2;
  localparam int unsigned SW_RESTORE = 3;
  localparam int unsigned SW_SUPPLY  = 4;
  localparam int unsigned SW_HOLD    = 5;
  localparam int unsigned SW_OVERT   = 6;

  // interrupt status bit positions
  localparam int unsigned EV_BREAK  = 0;
  localparam int unsigned EV_PFAIL  = 1;
  localparam int unsigned EV_HALT   = 2;
  localparam int unsigned EV_N      = 3;

  // register map of the plain software port
  localparam logic [3:0] REG_STATUS = 4'h0;  // sticky events, write one clears
  localparam logic [3:0] REG_MASK   = 4'h1;  // interrupt mask
  localparam logic [3:0] REG_STATE  = 4'h2;  // run/step/hold/power state
  localparam logic [3:0] REG_PC     = 4'h3;  // program counter
  localparam logic [3:0] REG_IR     = 4'h4;  // instruction register
  localparam logic [EV_N-1:0] MASK_RESET = 3'h0;

  // sequencer states, gray along run path
  typedef enum logic [2:0] {
    ST_HALT  = 3'b000,
    ST_EXEC  = 3'b001,
    ST_FETCH = 3'b011,
    ST_RUN   = 3'b010,
    ST_FORCE = 3'b110
  } seq_state_type;

  // request to the processor sequencer
  typedef struct packed {
    logic              exec;      // execute instruction in ir
    logic              fetch;     // fetch word at pc into ir
    logic              force_fix; // execute word at fixed location
    logic              cond_ok;   // switch condition satisfied
  } seq_req_type;

  // answer from the processor sequencer
  typedef struct packed {
    logic              done;      // whole instruction complete
    logic              is_jump;   // completed instruction was a jump
    logic              is_halt;   // completed instruction was halt
    logic              pc_adv;    // counter advance requested
    logic [WORD_W-1:0] pc_load;   // counter value after instruction
    logic [WORD_W-1:0] fetched;   // fetched instruction word
  } seq_ans_type;

  // lamp outputs
  typedef struct packed {
    logic run;
    logic step;
    logic hold;
    logic supply;
    logic restore;
  } lamp_type;

endpackage : console_step_pkg

/* File: rtl/switch_sync.sv */
// two-flop synchroniser and rising-edge detector for console switches
`timescale 1ns/1ps
`default_nettype none
module switch_sync
  import console_step_pkg::*;
#(
  parameter int unsigned N = SW_N        // switch count
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic [N-1:0] sw_raw,
  output logic      [N-1:0] sw_level,
  output logic      [N-1:0] sw_rise,
  output logic      [N-1:0] sw_fall
);

  logic [N-1:0] meta_r;                  // first stage, read only by sync_r
  logic [N-1:0] sync_r;                  // second stage
  logic [N-1:0] prev_r;                  // delayed copy for edges

  initial begin
    if (N < 1) $error("switch_sync needs at least one switch");
  end

  // synchronise, one pair of flops per switch
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_sw
      always_ff @(posedge core_clk) begin
        if (rst) begin
          meta_r[g] <= 1'b0;
          sync_r[g] <= 1'b0;
          prev_r[g] <= 1'b0;
        end else begin
          meta_r[g] <= sw_raw[g];
          sync_r[g] <= meta_r[g];
          prev_r[g] <= sync_r[g];
        end
      end
      // one pulse per press edge
      assign sw_rise[g] = sync_r[g] & ~prev_r[g]; // RULE18
      assign sw_fall[g] = ~sync_r[g] & prev_r[g];
    end
  endgenerate

  assign sw_level = sync_r;

endmodule : switch_sync
`default_nettype wire

/* File: tb/console_step_control_test.sv */
// self-checking bench for the console step control block
`timescale 1ns/1ps
`default_nettype none
module console_step_control_test;
  import console_step_pkg::*;
  logic        core_clk, rst, supply_sw, hold_sw, maint_hold, overtemp;
  logic        reg_entry_req, reg_clear_req, cond_inst, jump_on, halt_on;
  logic        reg_wr, reg_rd, entry_allow, clear_allow, mem_power_on, pfail_irq, irq;
  logic [3:0]  mom;       // momentary run, step, break, restore
  logic [3:0]  reg_addr;
  logic [2:0]  sense_sw, lat;
  logic [15:0] cur_inst, pc_r, ir_r, reg_wdata, reg_rdata, pc0, ir0, d;
  seq_req_type seq_req;
  seq_ans_type seq_ans;
  lamp_type    lamps;
  int          n_errors, compares, i, n_force, n_pfail, f0;

  console_step_control console_step_control_i (.core_clk(core_clk), .rst(rst),
    .run_sw(mom[0]), .step_sw(mom[1]), .break_sw(mom[2]), .restore_sw(mom[3]),
    .supply_sw(supply_sw), .hold_sw(hold_sw), .maint_hold(maint_hold),
    .sense_sw(sense_sw), .overtemp(overtemp), .reg_entry_req(reg_entry_req),
    .reg_clear_req(reg_clear_req), .cond_inst(cond_inst), .cur_inst(cur_inst),
    .seq_ans(seq_ans), .seq_req(seq_req), .pc_r(pc_r), .ir_r(ir_r),
    .entry_allow(entry_allow), .clear_allow(clear_allow), .mem_power_on(mem_power_on),
    .pfail_irq(pfail_irq), .lamps(lamps), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  seq_model seq_model_i (.core_clk(core_clk), .rst(rst), .seq_req(seq_req), .pc_r(pc_r),
    .lat(lat), .jump_on(jump_on), .halt_on(halt_on), .seq_ans(seq_ans));

  // expected memory word, same scheme the sequencer model serves
  function automatic logic [15:0] mem_word(input logic [15:0] a);
    return {a[7:0], ~a[7:0]};
  endfunction : mem_word

  task automatic check(input string w, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask : check

  task automatic cb(input string w, input logic e, input logic g);
    check(w, {15'h0, e}, {15'h0, g});
  endtask : cb

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  // one press: held long enough to pass the synchroniser
  task automatic press(input int s);
    @(posedge core_clk);
    mom[s] <= 1'b1;
    repeat (4) @(posedge core_clk);
    mom[s] <= 1'b0;
    tick(4);
  endtask : press

  // step press, then bounded wait until the sequencer goes idle
  task automatic step_once();
    press(SW_STEP);
    for (int k = 0; k < 200 && (seq_req.exec | seq_req.fetch); k++) @(posedge core_clk);
    tick(2);
  endtask : step_once

  task automatic reg_write(input logic [3:0] a, input logic [15:0] v);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [3:0] a, output logic [15:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1 v = reg_rdata;
  endtask : reg_read

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  // clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // event counters for pulses
  always @(posedge core_clk) begin
    if (seq_req.force_fix) n_force++;
    if (pfail_irq) n_pfail++;
  end

  // watchdog
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    wrap_up();
  end

  initial begin
    {rst, mom, supply_sw, hold_sw, maint_hold, overtemp} = 9'h100;
    {reg_entry_req, reg_clear_req, cond_inst, jump_on, halt_on, reg_wr, reg_rd} = 7'h0;
    {sense_sw, lat, reg_addr, cur_inst, reg_wdata} = 42'h0;
    supply_sw = 1'b1;
    void'($urandom(87927));
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    tick(4);
    check("pc reset", PC_RESET, pc_r);
    check("ir reset", IR_RESET, ir_r);
    cb("step lamp reset", 1'b1, lamps.step);
    reg_read(REG_MASK, d);
    check("mask reset", 16'h0000, d);
    reg_read(4'hf, d);
    check("unmapped read", 16'h0000, d);
    // single steps, first with the longest completion time
    for (i = 0; i < 4; i++) begin
      pc0 = pc_r;
      @(posedge core_clk);
      lat <= (i == 0) ? 3'h7 : 3'($urandom_range(7));
      step_once();
      check("pc after step", pc0 + 16'h0001, pc_r);
      check("ir after step", mem_word(pc0 + 16'h0001), ir_r);
      cb("halted after step", 1'b1, lamps.step);
    end
    // counter and instruction as software sees them after the last step
    reg_read(REG_PC, d);
    check("pc read", pc0 + 16'h0001, d);
    reg_read(REG_IR, d);
    check("ir read", mem_word(pc0 + 16'h0001), d);
    // hold mode steps
    @(posedge core_clk);
    hold_sw <= 1'b1;
    tick(5);
    cb("hold lamp", 1'b1, lamps.hold);
    ir0 = ir_r;
    for (i = 0; i < 2; i++) begin
      pc0 = pc_r;
      step_once();
      check("pc hold", pc0 + 16'h0001, pc_r);
      check("ir hold", ir0, ir_r);
    end
    @(posedge core_clk);
    hold_sw <= 1'b0;
    // sense gating over every switch pattern
    for (i = 0; i < 16; i++) begin
      @(posedge core_clk);
      sense_sw  <= 3'(i);
      cond_inst <= i[3];
      cur_inst  <= 16'($urandom);
      tick(5);
      cb("cond", cond_inst & |(sense_sw & cur_inst[8:6]), seq_req.cond_ok);
    end
    // break while halted is ignored
    f0 = n_force;
    press(SW_BREAK);
    check("break halted", 16'(f0), 16'(n_force));
    // run mode
    press(SW_RUN);
    cb("run lamp", 1'b1, lamps.run);
    @(posedge core_clk);
    reg_entry_req <= 1'b1;
    reg_clear_req <= 1'b1;
    hold_sw       <= 1'b1;
    tick(5);
    cb("entry in run", 1'b0, entry_allow);
    cb("clear in run", 1'b0, clear_allow);
    cb("hold lamp in run", 1'b0, lamps.hold);
    @(posedge core_clk);
    hold_sw    <= 1'b0;
    maint_hold <= 1'b1;
    tick(20);
    ir0 = ir_r;
    tick(30);
    check("ir forced hold", ir0, ir_r);
    @(posedge core_clk);
    maint_hold <= 1'b0;
    f0 = n_force;
    press(SW_BREAK);
    tick(20);
    cb("forced op", 1'b1, n_force != f0);
    cb("run after break", 1'b1, lamps.run);
    step_once();
    cb("run lamp off", 1'b0, lamps.run);
    cb("step lamp on", 1'b1, lamps.step);
    cb("entry halted", 1'b1, entry_allow);
    // forced jump ends the run
    press(SW_RUN);
    @(posedge core_clk);
    jump_on <= 1'b1;
    press(SW_BREAK);
    tick(30);
    cb("jump after break", 1'b0, lamps.run);
    @(posedge core_clk);
    jump_on <= 1'b0;
    // halt instruction stops run
    press(SW_RUN);
    @(posedge core_clk);
    halt_on <= 1'b1;
    tick(40);
    cb("halt stops", 1'b0, lamps.run);
    reg_read(REG_STATUS, d);
    cb("status halt", 1'b1, d[EV_HALT]);
    cb("status break", 1'b1, d[EV_BREAK]);
    // thermal trip and restore by switch
    reg_write(REG_MASK, 16'h0007);
    reg_write(REG_STATUS, 16'h0007);
    tick(2);
    cb("irq cleared", 1'b0, irq);
    f0 = n_pfail;
    @(posedge core_clk);
    halt_on  <= 1'b0;
    overtemp <= 1'b1;
    tick(8);
    check("pfail pulses", 16'(f0 + 1), 16'(n_pfail));
    cb("mem power off", 1'b0, mem_power_on);
    cb("restore lamp", 1'b1, lamps.restore);
    cb("supply lamp", 1'b0, lamps.supply);
    cb("irq pfail", 1'b1, irq);
    reg_read(REG_STATE, d);
    check("state word tripped", 16'h0020, d);
    @(posedge core_clk);
    overtemp <= 1'b0;
    press(SW_RESTORE);
    cb("restored", 1'b1, mem_power_on);
    cb("restore lamp off", 1'b0, lamps.restore);
    // second trip, restore by supply off then on
    @(posedge core_clk);
    overtemp <= 1'b1;
    tick(8);
    @(posedge core_clk);
    overtemp  <= 1'b0;
    supply_sw <= 1'b0;
    tick(6);
    @(posedge core_clk);
    supply_sw <= 1'b1;
    tick(6);
    cb("supply cycled", 1'b1, mem_power_on);
    reg_write(REG_MASK, 16'h0000);
    tick(1);
    cb("irq masked", 1'b0, irq);
    reg_write(REG_STATUS, 16'h0007);
    reg_write(REG_MASK, 16'h0007);
    tick(1);
    cb("irq after clear", 1'b0, irq);
    wrap_up();
  end
endmodule : console_step_control_test
`default_nettype wire

/* File: tb/seq_model.sv */
// behavioural processor sequencer answering the console step control
`timescale 1ns/1ps
`default_nettype none
module seq_model
  import console_step_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  var  seq_req_type       seq_req,
  input  wire logic [WORD_W-1:0] pc_r,
  input  wire logic [2:0]        lat,
  input  wire logic              jump_on,
  input  wire logic              halt_on,
  output var  seq_ans_type       seq_ans
);
  logic              busy;   // any request up
  logic [2:0]        cnt_r;  // cycles waited so far
  logic              done_r; // one-cycle completion pulse
  logic [WORD_W-1:0] word;   // memory word at the counter

  assign busy = seq_req.exec | seq_req.fetch | seq_req.force_fix;
  assign word = {pc_r[7:0], ~pc_r[7:0]};

  // done only after the whole op, indirection included, is over
  always_ff @(posedge core_clk) begin
    if (rst || !busy || done_r) begin
      cnt_r  <= 3'h0;
      done_r <= 1'b0;
    end else if (cnt_r >= lat) begin
      done_r <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 3'h1;
    end
  end

  // fields mean something only with done; pc_load and fetched scrambled otherwise, flags low
  // no block-transfer peripheral behind the model, so a stepped op always ends
  always_comb begin
    seq_ans.done    = done_r;
    seq_ans.is_jump = done_r & jump_on;
    seq_ans.is_halt = done_r & halt_on;
    seq_ans.pc_adv  = done_r;
    seq_ans.pc_load = done_r ? pc_r + 16'h0001 : ~pc_r;
    seq_ans.fetched = done_r ? word : ~word;
  end
endmodule : seq_model
`default_nettype wire
